// file: rtl/tpf_pkg.sv
// Package with constants and types shared by the timing pulse FIFO status block
package tpf_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int NCHAN = 2;
  localparam int FIFO_DEPTH = 8;
  // Register indices; byte address is four times the index
  localparam logic [15:0] GEN0_STATUS_IDX = 16'hfff8;
  localparam logic [15:0] GEN1_STATUS_IDX = 16'hfff9;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'hfff0;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hfff1;
  // Status register fields
  localparam int COUNT_LSB = 0;
  localparam int COUNT_W = 3;
  localparam int EMPTY_BIT = 3;
  localparam int FULL_BIT = 4;
  localparam int IRQ_EN_BIT = 5;
  localparam logic [COUNT_W-1:0] COUNT_RST = 3'h0;
  localparam logic EMPTY_RST = 1'b1;
  localparam logic FULL_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  // Interrupt status and mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_EMPTY0 = 0;
  localparam int IRQ_EMPTY1 = 1;
  localparam int IRQ_FULL0 = 2;
  localparam int IRQ_FULL1 = 3;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TPF_WR_COLLECT = 2'b01, TPF_WR_RESP = 2'b10} tpf_wr_state_e;
  typedef enum logic [1:0] {TPF_RD_IDLE = 2'b01, TPF_RD_RESP = 2'b10} tpf_rd_state_e;
endpackage

// file: rtl/tpf_chan_if.sv
// Interface between the register logic and one channel's fill tracker
`timescale 1ns/1ps
`default_nettype none
interface tpf_chan_if;
  logic push;
  logic pop;
  logic clear;
  logic [tpf_pkg::COUNT_W-1:0] count;
  logic empty;
  logic full;
  modport track (input push, input pop, input clear, output count, output empty, output full);
  modport user (output push, output pop, output clear, input count, input empty, input full);
endinterface
`default_nettype wire

// file: rtl/tpf_level_track.sv
// Fill level tracker of one pulse generator FIFO
`timescale 1ns/1ps
`default_nettype none
module tpf_level_track #(
  parameter int DEPTH = tpf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel
  tpf_chan_if.track chan
);
  import tpf_pkg::*;
  localparam int LW = $clog2(DEPTH + 1);
  logic [LW-1:0] level;
  logic [LW-1:0] next_level;
  logic do_push;
  logic do_pop;
  // Push into a full FIFO and pop from an empty one are dropped
  assign do_push = chan.push && (level != LW'(DEPTH));
  assign do_pop = chan.pop && (level != '0);
  always_comb begin
    next_level = level;
    if (chan.clear) begin
      next_level = '0;
    end else if (do_push && !do_pop) begin
      next_level = level + LW'(1);
    end else if (do_pop && !do_push) begin
      next_level = level - LW'(1);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= '0;
      chan.count <= COUNT_RST;
      chan.empty <= EMPTY_RST;
      chan.full <= FULL_RST;
    end else begin
      level <= next_level;
      // Count wraps to zero at eight entries
      chan.count <= next_level[COUNT_W-1:0];
      chan.empty <= (next_level == '0);
      chan.full <= (next_level == LW'(DEPTH));
    end
  end
endmodule // tpf_level_track
`default_nettype wire

// file: rtl/tpf_irq_unit.sv
// Sticky interrupt status, mask and interrupt line
`timescale 1ns/1ps
`default_nettype none
module tpf_irq_unit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events and software access
  input wire logic [tpf_pkg::IRQ_W-1:0] events,
  input wire logic clear_stb,
  input wire logic [tpf_pkg::IRQ_W-1:0] clear_bits,
  input wire logic mask_stb,
  input wire logic [tpf_pkg::IRQ_W-1:0] mask_bits,
  // State
  output logic [tpf_pkg::IRQ_W-1:0] status,
  output logic [tpf_pkg::IRQ_W-1:0] mask,
  output logic irq
);
  import tpf_pkg::*;
  logic [IRQ_W-1:0] next_status;
  logic [IRQ_W-1:0] next_mask;
  // An event in the cycle of its own clear still sets the bit
  assign next_status = (status & ~(clear_stb ? clear_bits : '0)) | events;
  assign next_mask = mask_stb ? mask_bits : mask;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= IRQ_STATUS_RST;
      mask <= IRQ_MASK_RST;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end
endmodule // tpf_irq_unit
`default_nettype wire

// file: rtl/tpf_top.sv
// Status and interrupt logic for the two timing pulse generator FIFOs
// How it works
// - three-bit count, zero means empty or full
// - empty reported when empty flag and zero count
// - full reported when full flag and zero count
// - read-only empty flag, bit 3, resets high
// - read-only full flag, bit 4, resets low
// - write-only empty interrupt enable, bit 5
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tpf_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [tpf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [tpf_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [tpf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [tpf_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // FIFO activity of generator zero
  input wire logic gen0_push,
  input wire logic gen0_pop,
  input wire logic gen0_count_reset,
  // FIFO activity of generator one
  input wire logic gen1_push,
  input wire logic gen1_pop,
  input wire logic gen1_count_reset,
  // Interrupts
  output logic gen0_empty_irq_req,
  output logic gen1_empty_irq_req,
  output logic irq
);
  import tpf_pkg::*;

  // Word index of a byte address
  function automatic logic [ADDR_W-3:0] word_of(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction

  // True when a byte address falls on the given register word; the low two bits are ignored
  function automatic logic hits_word(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-3:0] idx
  );
    return word_of(addr) == idx;
  endfunction

  // Status byte as software reads it; the enable bit is write-only
  function automatic logic [DATA_W-1:0] status_word(
    input logic [COUNT_W-1:0] count,
    input logic empty,
    input logic full
  );
    logic [DATA_W-1:0] w;
    w = '0;
    w[COUNT_LSB +: COUNT_W] = count;
    w[EMPTY_BIT] = empty;
    w[FULL_BIT] = full;
    w[IRQ_EN_BIT] = 1'b0;
    return w;
  endfunction

  // Channel trackers
  tpf_chan_if chan0 ();
  tpf_chan_if chan1 ();

  assign chan0.push = gen0_push;
  assign chan0.pop = gen0_pop;
  assign chan0.clear = gen0_count_reset;
  assign chan1.push = gen1_push;
  assign chan1.pop = gen1_pop;
  assign chan1.clear = gen1_count_reset;

  tpf_level_track #(
    .DEPTH(FIFO_DEPTH)
  ) u_track0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .chan(chan0.track)
  );

  tpf_level_track #(
    .DEPTH(FIFO_DEPTH)
  ) u_track1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .chan(chan1.track)
  );

  // Flags behind interrupt events and requests combine the flag with a zero count; reads return the raw flags
  logic gen0_is_empty;
  logic gen1_is_empty;
  logic gen0_is_full;
  logic gen1_is_full;
  assign gen0_is_empty = chan0.empty && (chan0.count == COUNT_RST);
  assign gen1_is_empty = chan1.empty && (chan1.count == COUNT_RST);
  assign gen0_is_full = chan0.full && (chan0.count == COUNT_RST);
  assign gen1_is_full = chan1.full && (chan1.count == COUNT_RST);

  // Write channel state
  tpf_wr_state_e wr_state;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic commit;
  logic lane0;
  // Commit waits a cycle after both halves are in, so decode sees the registered address
  assign commit = (wr_state == TPF_WR_COLLECT) && !s_axi_awready && !s_axi_wready;
  assign lane0 = w_strb[0];

  // Write decode
  logic wr_gen0;
  logic wr_gen1;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_mapped;
  assign wr_gen0 = hits_word(aw_addr, GEN0_STATUS_IDX);
  assign wr_gen1 = hits_word(aw_addr, GEN1_STATUS_IDX);
  assign wr_irq_status = hits_word(aw_addr, IRQ_STATUS_IDX);
  assign wr_irq_mask = hits_word(aw_addr, IRQ_MASK_IDX);
  assign wr_mapped = wr_gen0 || wr_gen1 || wr_irq_status || wr_irq_mask;
  // Unmapped words answer with an error and change nothing
  logic [1:0] wr_resp;
  assign wr_resp = wr_mapped ? RESP_OKAY : RESP_SLVERR;

  // Register writes act in the commit cycle, and only with byte lane zero enabled
  logic wr_stb;
  logic irq_clear_stb;
  logic irq_mask_stb;
  logic gen0_enable_stb;
  logic gen1_enable_stb;
  assign wr_stb = commit && lane0;
  assign irq_clear_stb = wr_stb && wr_irq_status;
  assign irq_mask_stb = wr_stb && wr_irq_mask;
  assign gen0_enable_stb = wr_stb && wr_gen0;
  assign gen1_enable_stb = wr_stb && wr_gen1;

  // Read decode
  logic rd_gen0;
  logic rd_gen1;
  logic rd_irq_status;
  logic rd_irq_mask;
  logic rd_mapped;
  logic [DATA_W-1:0] rd_word;
  assign rd_gen0 = hits_word(s_axi_araddr, GEN0_STATUS_IDX);
  assign rd_gen1 = hits_word(s_axi_araddr, GEN1_STATUS_IDX);
  assign rd_irq_status = hits_word(s_axi_araddr, IRQ_STATUS_IDX);
  assign rd_irq_mask = hits_word(s_axi_araddr, IRQ_MASK_IDX);
  assign rd_mapped = rd_gen0 || rd_gen1 || rd_irq_status || rd_irq_mask;
  logic [1:0] rd_resp;
  assign rd_resp = rd_mapped ? RESP_OKAY : RESP_SLVERR;

  // Interrupt enables and interrupt unit
  logic gen0_empty_irq_enable;
  logic gen1_empty_irq_enable;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_events;
  logic gen0_was_empty;
  logic gen1_was_empty;
  logic gen0_was_full;
  logic gen1_was_full;

  // Status words of both channels as software reads them
  logic [DATA_W-1:0] gen0_status_word;
  logic [DATA_W-1:0] gen1_status_word;
  assign gen0_status_word = status_word(chan0.count, chan0.empty, chan0.full);
  assign gen1_status_word = status_word(chan1.count, chan1.empty, chan1.full);

  assign rd_word = rd_gen0 ? gen0_status_word :
                   rd_gen1 ? gen1_status_word :
                   rd_irq_status ? DATA_W'(irq_status) :
                   rd_irq_mask ? DATA_W'(irq_mask) : '0;

  // Empty events fire on the edge into empty, only while enabled
  logic gen0_became_empty;
  logic gen1_became_empty;
  assign gen0_became_empty = gen0_is_empty && !gen0_was_empty;
  assign gen1_became_empty = gen1_is_empty && !gen1_was_empty;
  assign irq_events[IRQ_EMPTY0] = gen0_became_empty && gen0_empty_irq_enable;
  assign irq_events[IRQ_EMPTY1] = gen1_became_empty && gen1_empty_irq_enable;
  // Full events have no enable of their own; the mask alone gates them
  assign irq_events[IRQ_FULL0] = gen0_is_full && !gen0_was_full;
  assign irq_events[IRQ_FULL1] = gen1_is_full && !gen1_was_full;

  tpf_irq_unit u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .events(irq_events),
    .clear_stb(irq_clear_stb),
    .clear_bits(w_data[IRQ_W-1:0]),
    .mask_stb(irq_mask_stb),
    .mask_bits(w_data[IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // Edge history starts empty so reset itself raises nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen0_was_empty <= 1'b1;
      gen1_was_empty <= 1'b1;
      gen0_was_full <= 1'b0;
      gen1_was_full <= 1'b0;
    end else begin
      gen0_was_empty <= gen0_is_empty;
      gen1_was_empty <= gen1_is_empty;
      gen0_was_full <= gen0_is_full;
      gen1_was_full <= gen1_is_full;
    end
  end

  // Enables cannot be read back, so a read-modify-write would clear them
  logic next_gen0_empty_irq_enable;
  logic next_gen1_empty_irq_enable;
  assign next_gen0_empty_irq_enable = gen0_enable_stb ? w_data[IRQ_EN_BIT] : gen0_empty_irq_enable;
  assign next_gen1_empty_irq_enable = gen1_enable_stb ? w_data[IRQ_EN_BIT] : gen1_empty_irq_enable;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen0_empty_irq_enable <= IRQ_EN_RST;
      gen1_empty_irq_enable <= IRQ_EN_RST;
    end else begin
      gen0_empty_irq_enable <= next_gen0_empty_irq_enable;
      gen1_empty_irq_enable <= next_gen1_empty_irq_enable;
    end
  end

  // Per-channel request is a level while enabled and empty
  logic next_gen0_empty_irq_req;
  logic next_gen1_empty_irq_req;
  assign next_gen0_empty_irq_req = gen0_empty_irq_enable && gen0_is_empty;
  assign next_gen1_empty_irq_req = gen1_empty_irq_enable && gen1_is_empty;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen0_empty_irq_req <= 1'b0;
      gen1_empty_irq_req <= 1'b0;
    end else begin
      gen0_empty_irq_req <= next_gen0_empty_irq_req;
      gen1_empty_irq_req <= next_gen1_empty_irq_req;
    end
  end

  // Write side: address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= TPF_WR_COLLECT;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
    end else begin
      unique case (wr_state)
        TPF_WR_COLLECT: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
          end
          if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
            wr_state <= TPF_WR_RESP;
          end
        end
        TPF_WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state <= TPF_WR_COLLECT;
          end
        end
      endcase
    end
  end

  // Read side: data is sampled at the address handshake
  tpf_rd_state_e rd_state;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= TPF_RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      unique case (rd_state)
        TPF_RD_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
            rd_state <= TPF_RD_RESP;
          end
        end
        TPF_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state <= TPF_RD_IDLE;
          end
        end
      endcase
    end
  end

  // Protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_strb[3:1]};

endmodule // tpf_top
`default_nettype wire

// file: tb/tpf_top_props.sv
// Assertions on the bus and status ports of the pulse FIFO status block
`timescale 1ns/1ps
`default_nettype none
module tpf_top_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tpf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [tpf_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Generator zero
  input wire logic gen0_push,
  input wire logic gen0_pop,
  input wire logic gen0_count_reset,
  input wire logic gen0_empty_irq_req
);
  import tpf_pkg::*;
  logic st_rd;
  // Both status words share address bits above bit 2
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) st_rd <= s_axi_araddr[17:3] == GEN0_STATUS_IDX[15:1];
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  enable_hidden_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("enable or upper bits read nonzero");
  empty_count_a: assert property (s_axi_rvalid && st_rd && s_axi_rdata[3] |-> s_axi_rdata[4:0] == 5'h08)
    else $error("empty flag with count or full");
  full_count_a: assert property (s_axi_rvalid && st_rd && s_axi_rdata[4] |-> s_axi_rdata[3:0] == 4'h0)
    else $error("full flag with count or empty");
  push_req_a: assert property (gen0_push && !gen0_pop && !gen0_count_reset |-> ##2 !gen0_empty_irq_req)
    else $error("empty request after push");
endmodule // tpf_top_props
bind tpf_top tpf_top_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .gen0_push, .gen0_pop, .gen0_count_reset, .gen0_empty_irq_req);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the pulse FIFO status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tpf_pkg::*;
  // Status words of the two channels have their own addresses
  localparam logic [17:0] A0 = {GEN0_STATUS_IDX, 2'b00};
  localparam logic [17:0] A1 = {GEN1_STATUS_IDX, 2'b00};
  localparam logic [17:0] AS = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [17:0] AM = {IRQ_MASK_IDX, 2'b00};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, req0, req1, irq;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [5:0] act;
  int n_fail, n_checks;
  tpf_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .gen0_push(act[0]), .gen0_pop(act[1]), .gen0_count_reset(act[2]), .gen1_push(act[3]), .gen1_pop(act[4]),
    .gen1_count_reset(act[5]), .gen0_empty_irq_req(req0), .gen1_empty_irq_req(req1), .irq);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] st(input logic [2:0] c, input logic e, input logic f);
    return {27'h0, f, e, c};
  endfunction
  // Values are read in the active region, so they are the ones sampled at the edge
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        break;
      end
    end
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        break;
      end
    end
  endtask
  task automatic pulse(input logic [5:0] v, input int n);
    repeat (n) begin
      @(posedge aclk);
      act <= v;
      @(posedge aclk);
      act <= 6'h0;
    end
  endtask
  // Order: irq, gen1 request, gen0 request
  task automatic flags(input logic [2:0] e);
    @(posedge aclk);
    chk({29'h0, irq, req1, req0}, {29'h0, e});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    $display("watchdog expired");
    wrap_up;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, act} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    flags(3'b000);
    rd(A0, st(0, 1, 0), RESP_OKAY);
    rd(A1, st(0, 1, 0), RESP_OKAY);
    rd(AS, 32'h0, RESP_OKAY);
    rd(AM, 32'h0, RESP_OKAY);
    $display("reset test done");
    wr(A0, 32'h3f, RESP_OKAY);
    rd(A0, st(0, 1, 0), RESP_OKAY);
    flags(3'b001);
    pulse(6'h01, 3);
    rd(A0, st(3, 0, 0), RESP_OKAY);
    flags(3'b000);
    pulse(6'h01, 5);
    rd(A0, st(0, 0, 1), RESP_OKAY);
    pulse(6'h01, 1);
    rd(A0, st(0, 0, 1), RESP_OKAY);
    rd(AS, 32'h4, RESP_OKAY);
    flags(3'b000);
    wr(AM, 32'h4, RESP_OKAY);
    flags(3'b100);
    wr(AS, 32'h4, RESP_OKAY);
    rd(AS, 32'h0, RESP_OKAY);
    flags(3'b000);
    $display("fill test done");
    pulse(6'h02, 1);
    rd(A0, st(7, 0, 0), RESP_OKAY);
    pulse(6'h02, 7);
    rd(A0, st(0, 1, 0), RESP_OKAY);
    flags(3'b001);
    rd(AS, 32'h1, RESP_OKAY);
    wr(A0, 32'h0, RESP_OKAY);
    flags(3'b000);
    $display("drain test done");
    pulse(6'h08, 5);
    pulse(6'h18, 1);
    rd(A1, st(5, 0, 0), RESP_OKAY);
    pulse(6'h20, 1);
    rd(A1, st(0, 1, 0), RESP_OKAY);
    flags(3'b000);
    wr(A1, 32'h20, RESP_OKAY);
    flags(3'b010);
    pulse(6'h08, 8);
    rd(A1, st(0, 0, 1), RESP_OKAY);
    flags(3'b000);
    pulse(6'h20, 1);
    rd(AS, 32'hb, RESP_OKAY);
    rd(18'h0, 32'h0, RESP_SLVERR);
    wr(18'h0, 32'h20, RESP_SLVERR);
    flags(3'b010);
    s_axi_wstrb <= 4'he;
    wr(AM, 32'hf, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(AM, 32'h4, RESP_OKAY);
    wr(AM, 32'hf, RESP_OKAY);
    flags(3'b110);
    wr(AS, 32'hf, RESP_OKAY);
    rd(AS, 32'h0, RESP_OKAY);
    flags(3'b010);
    $display("channel one test done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    flags(3'b000);
    rd(A1, st(0, 1, 0), RESP_OKAY);
    rd(AS, 32'h0, RESP_OKAY);
    $display("second reset test done");
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
